// [src/mdcr_pkg.sv]
// Purpose: constants for the metering datapath configuration register bank
// Assumes: registers reached over a 32-bit word access port, 16-bit register addresses
// Notes: offsets are register addresses as printed
package mdcr_pkg;
  // ==========================================================
  // register addresses
  localparam logic [15:0] ADDR_DATAPATH_CONFIG = 16'h0020;
  localparam logic [15:0] ADDR_CHAN_B_GAIN = 16'h0023;
  localparam logic [15:0] ADDR_AUTOCAL_CONFIG = 16'h0030;
  // ==========================================================
  // datapath_config field positions
  localparam int POS_HIGHPASS_BYPASS_ALL = 0;
  localparam int POS_CFG_SPARE = 1;
  localparam int POS_CHAN_B_INTEGRATOR_ON = 2;
  localparam int POS_ZERO_CROSS_SOURCE = 3;
  localparam int POS_OVERCURRENT_RMS_SOURCE = 4;
  localparam int POS_NOMINAL_VOLTAGE_USE = 5;
  localparam int POS_ACTIVE_LPF_BYPASS = 7;
  localparam int POS_REACTIVE_LPF_BYPASS = 8;
  // ==========================================================
  // autocal_config field positions
  localparam int POS_CALIBRATION_MODE_GATE = 0;
  localparam int POS_CAL_RUN = 1;
  localparam int POS_CHAN_A_CAL_POWER_MODE = 2;
  localparam int POS_CHAN_B_CAL_POWER_MODE = 3;
  localparam int POS_CHAN_A_CAL_ENABLE = 4;
  localparam int POS_CHAN_B_CAL_ENABLE = 5;
  localparam int POS_VOLTAGE_CAL_ENABLE = 6;
  // ==========================================================
  // writable masks and reset values
  localparam logic [31:0] MASK_DATAPATH_CONFIG = 32'h0000_01BF;
  localparam logic [31:0] MASK_CHAN_B_GAIN = 32'h0000_0003;
  localparam logic [31:0] MASK_AUTOCAL_CONFIG = 32'h0000_007F;
  localparam logic [31:0] RST_DATAPATH_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_CHAN_B_GAIN = 32'h0000_0000;
  localparam logic [31:0] RST_AUTOCAL_CONFIG = 32'h0000_0000;
  // ==========================================================
  // gain codes
  typedef enum logic [1:0]
  {
    MDCR_GAIN_X1 = 2'b00,
    MDCR_GAIN_X2 = 2'b01,
    MDCR_GAIN_X4 = 2'b10
  } mdcr_gain_t;
  localparam logic [2:0] GAIN_FACTOR_X1 = 3'h1;
  localparam logic [2:0] GAIN_FACTOR_X2 = 3'h2;
  localparam logic [2:0] GAIN_FACTOR_X4 = 3'h4;
endpackage

// [src/mdcr_word_reg.sv]
// Purpose: one masked read/write configuration word
// Assumes: synchronous active-high reset
// Notes: bits outside the mask hold zero
`timescale 1ns/100ps
`default_nettype none
module mdcr_word_reg
#(
  parameter logic [31:0] MASK = 32'h0000_0000,
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_value
);
  // ==========================================================
  // storage: only mask bits are writable
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_value <= RESET_VALUE;
    end
    else if (i_wr)
    begin
      o_value <= i_wdata & MASK;
    end
  end
endmodule
`default_nettype wire

// [src/mdcr_regs.sv]
// Purpose: configuration registers steering the metering datapath
// Assumes: access port delivers one-cycle read/write strobes with address
// Notes: read data registered, one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module mdcr_regs
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_reactive_lpf_bypass,
  output logic o_active_lpf_bypass,
  output logic o_nominal_voltage_use,
  output logic o_overcurrent_rms_source,
  output logic o_zero_cross_source,
  output logic o_chan_b_integrator_on,
  output logic o_highpass_bypass_all,
  output logic [1:0] o_chan_b_amp_gain,
  output logic [2:0] o_chan_b_gain_factor,
  output logic o_voltage_cal_enable,
  output logic o_chan_b_cal_enable,
  output logic o_chan_a_cal_enable,
  output logic o_chan_b_cal_power_mode,
  output logic o_chan_a_cal_power_mode,
  output logic o_cal_run,
  output logic o_calibration_mode_gate,
  output logic o_cal_active
);
  logic [31:0] datapath_config;
  logic [31:0] chan_b_gain;
  logic [31:0] autocal_config;
  logic gate;
  logic wr_cfg;
  logic wr_gain;
  logic wr_cal;
  logic [31:0] next_rdata;
  logic hit_cfg;
  logic hit_gain;
  logic hit_cal;
  logic [2:0] next_gain_factor;
  logic [2:0] gain_factor;
  logic cal_active;

  // calibration mode bit gates the datapath words
  assign gate = autocal_config[mdcr_pkg::POS_CALIBRATION_MODE_GATE];

  // ==========================================================
  // address decode, one hit per mapped word
  // unmapped addresses hit nothing, so writes drop and reads give zero
  always_comb
  begin
    hit_cfg = 1'b0;
    hit_gain = 1'b0;
    hit_cal = 1'b0;
    case (i_addr)
      mdcr_pkg::ADDR_DATAPATH_CONFIG: hit_cfg = 1'b1;
      mdcr_pkg::ADDR_CHAN_B_GAIN: hit_gain = 1'b1;
      mdcr_pkg::ADDR_AUTOCAL_CONFIG: hit_cal = 1'b1;
      default: hit_cal = 1'b0;
    endcase
  end

  // ==========================================================
  // write decode
  // gate blocks datapath registers
  // calibration word stays open, else software could never leave the gate
  assign wr_cfg = i_wr && !gate && hit_cfg;
  assign wr_gain = i_wr && !gate && hit_gain;
  assign wr_cal = i_wr && hit_cal;

  // ==========================================================
  // register words
  // datapath config word
  mdcr_word_reg #(
    .MASK(mdcr_pkg::MASK_DATAPATH_CONFIG),
    .RESET_VALUE(mdcr_pkg::RST_DATAPATH_CONFIG)
  ) u_cfg (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_cfg),
    .i_wdata(i_wdata),
    .o_value(datapath_config)
  );

  mdcr_word_reg #(
    .MASK(mdcr_pkg::MASK_CHAN_B_GAIN),
    .RESET_VALUE(mdcr_pkg::RST_CHAN_B_GAIN)
  ) u_gain (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_gain),
    .i_wdata(i_wdata),
    .o_value(chan_b_gain)
  );

  mdcr_word_reg #(
    .MASK(mdcr_pkg::MASK_AUTOCAL_CONFIG),
    .RESET_VALUE(mdcr_pkg::RST_AUTOCAL_CONFIG)
  ) u_cal (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr(wr_cal),
    .i_wdata(i_wdata),
    .o_value(autocal_config)
  );

  // ==========================================================
  // read mux, reads of gated registers return zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      mdcr_pkg::ADDR_DATAPATH_CONFIG: next_rdata = gate ? 32'h0000_0000 : datapath_config;
      mdcr_pkg::ADDR_CHAN_B_GAIN: next_rdata = gate ? 32'h0000_0000 : chan_b_gain;
      mdcr_pkg::ADDR_AUTOCAL_CONFIG: next_rdata = autocal_config;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data register, held until the next read
  // a read beside a write in one cycle returns the old word
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_rdata <= 32'h0000_0000;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd;
      if (i_rd)
      begin
        o_rdata <= next_rdata;
      end
    end
  end

  // ==========================================================
  // datapath controls
  // each control is a plain bit of a stored word, so it comes from a flop
  // lpf bypasses
  assign o_reactive_lpf_bypass = datapath_config[mdcr_pkg::POS_REACTIVE_LPF_BYPASS];
  assign o_active_lpf_bypass = datapath_config[mdcr_pkg::POS_ACTIVE_LPF_BYPASS];
  assign o_nominal_voltage_use = datapath_config[mdcr_pkg::POS_NOMINAL_VOLTAGE_USE];
  assign o_overcurrent_rms_source = datapath_config[mdcr_pkg::POS_OVERCURRENT_RMS_SOURCE];
  assign o_zero_cross_source = datapath_config[mdcr_pkg::POS_ZERO_CROSS_SOURCE];
  assign o_chan_b_integrator_on = datapath_config[mdcr_pkg::POS_CHAN_B_INTEGRATOR_ON];
  assign o_highpass_bypass_all = datapath_config[mdcr_pkg::POS_HIGHPASS_BYPASS_ALL];

  // ==========================================================
  // channel B gain
  // gain code and decoded factor
  assign o_chan_b_amp_gain = chan_b_gain[1:0];
  // decode the incoming code; unused code 3 falls back to unity
  always_comb
  begin
    next_gain_factor = mdcr_pkg::GAIN_FACTOR_X1;
    case (i_wdata[1:0])
      mdcr_pkg::MDCR_GAIN_X2: next_gain_factor = mdcr_pkg::GAIN_FACTOR_X2;
      mdcr_pkg::MDCR_GAIN_X4: next_gain_factor = mdcr_pkg::GAIN_FACTOR_X4;
      default: next_gain_factor = mdcr_pkg::GAIN_FACTOR_X1;
    endcase
  end

  // factor flop loads with the code, so both change on the same edge
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      gain_factor <= mdcr_pkg::GAIN_FACTOR_X1;
    end
    else if (wr_gain)
    begin
      gain_factor <= next_gain_factor;
    end
  end
  assign o_chan_b_gain_factor = gain_factor;

  // ==========================================================
  // calibration controls
  // per-channel calibration enables
  assign o_voltage_cal_enable = autocal_config[mdcr_pkg::POS_VOLTAGE_CAL_ENABLE];
  assign o_chan_b_cal_enable = autocal_config[mdcr_pkg::POS_CHAN_B_CAL_ENABLE];
  assign o_chan_a_cal_enable = autocal_config[mdcr_pkg::POS_CHAN_A_CAL_ENABLE];
  assign o_chan_b_cal_power_mode = autocal_config[mdcr_pkg::POS_CHAN_B_CAL_POWER_MODE];
  assign o_chan_a_cal_power_mode = autocal_config[mdcr_pkg::POS_CHAN_A_CAL_POWER_MODE];
  assign o_cal_run = autocal_config[mdcr_pkg::POS_CAL_RUN];
  assign o_calibration_mode_gate = gate;

  // run only when gated
  // run and gate arrive in one word, so their product is loaded with it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cal_active <= 1'b0;
    end
    else if (wr_cal)
    begin
      cal_active <= i_wdata[mdcr_pkg::POS_CAL_RUN]
        && i_wdata[mdcr_pkg::POS_CALIBRATION_MODE_GATE];
    end
  end
  assign o_cal_active = cal_active;
endmodule
`default_nettype wire

// [test/mdcr_regs_props.sv]
// Purpose: port checker for mdcr_regs
// Assumes: one clock, synchronous reset
// Notes: bound from tb
`timescale 1ns/100ps
`default_nettype none
module mdcr_props
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic o_rvalid,
  input wire logic o_reactive_lpf_bypass,
  input wire logic o_highpass_bypass_all,
  input wire logic [1:0] o_chan_b_amp_gain,
  input wire logic [2:0] o_chan_b_gain_factor,
  input wire logic o_cal_run,
  input wire logic o_calibration_mode_gate,
  input wire logic o_cal_active
);
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========================================
  // sequences: config writes, open and gated
  sequence s_cfg_wr;
    i_wr && i_addr == 16'h0020 && !o_calibration_mode_gate;
  endsequence
  sequence s_gated_wr;
    i_wr && i_addr == 16'h0020 && o_calibration_mode_gate;
  endsequence
  // ==========================================
  // properties
  property p_rvalid; i_rd |=> o_rvalid; endproperty
  property p_no_rvalid; !i_rd |=> !o_rvalid; endproperty
  property p_react; s_cfg_wr |=> o_reactive_lpf_bypass == $past(i_wdata[8]); endproperty
  property p_hpf; s_cfg_wr |=> o_highpass_bypass_all == $past(i_wdata[0]); endproperty
  property p_gated; s_gated_wr |=> $stable(o_reactive_lpf_bypass); endproperty
  property p_gain_hold; !(i_wr && i_addr == 16'h0023) |=> $stable(o_chan_b_amp_gain); endproperty
  property p_factor;
    o_chan_b_gain_factor == (o_chan_b_amp_gain == 2'h1 ? 3'h2 :
      (o_chan_b_amp_gain == 2'h2 ? 3'h4 : 3'h1));
  endproperty
  property p_active; o_cal_active == (o_cal_run && o_calibration_mode_gate); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  a_no_rvalid: assert property (p_no_rvalid) else $error("read answer without read");
  a_react: assert property (p_react) else $error("reactive bypass not written");
  a_hpf: assert property (p_hpf) else $error("highpass bypass not written");
  a_gated: assert property (p_gated) else $error("config changed while gated");
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed unasked");
  a_factor: assert property (p_factor) else $error("gain factor wrong");
  a_active: assert property (p_active) else $error("calibration active wrong");
endmodule
`default_nettype wire

// [test/mdcr_host.sv]
// Purpose: host model driving the register port
// Assumes: one-cycle strobes, read answer one cycle later
// Notes: idle address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module mdcr_host
(
  input wire logic i_clk_sys,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [31:0] o_wdata
);
  // idle port at time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h0000_0000;
  end
  // one strobe cycle; read data taken with its valid
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge i_clk_sys);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk_sys);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    q = (i_rvalid === 1'b1) ? i_rdata : 32'hxxxx_xxxx;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for mdcr_regs
// Assumes: 40 MHz clock, host model drives the port
// Notes: rows write, read back and check outputs
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {logic [15:0] a; logic [31:0] d; logic [31:0] r; logic [17:0] o;} mdcr_row_t;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr, i_rd, o_rvalid, o_reactive_lpf_bypass, o_active_lpf_bypass;
  logic o_nominal_voltage_use, o_overcurrent_rms_source, o_zero_cross_source;
  logic o_chan_b_integrator_on, o_highpass_bypass_all, o_voltage_cal_enable;
  logic o_chan_b_cal_enable, o_chan_a_cal_enable, o_chan_b_cal_power_mode;
  logic o_chan_a_cal_power_mode, o_cal_run, o_calibration_mode_gate, o_cal_active;
  logic [15:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [1:0] o_chan_b_amp_gain;
  logic [2:0] o_chan_b_gain_factor;
  int checks = 0;
  int fail_count = 0;
  // all steering outputs except o_chan_b_amp_gain in one word
  wire logic [17:0] obs = {o_reactive_lpf_bypass, o_active_lpf_bypass, o_nominal_voltage_use,
    o_overcurrent_rms_source, o_zero_cross_source, o_chan_b_integrator_on,
    o_highpass_bypass_all, o_chan_b_gain_factor, o_voltage_cal_enable, o_chan_b_cal_enable,
    o_chan_a_cal_enable, o_chan_b_cal_power_mode, o_chan_a_cal_power_mode, o_cal_run,
    o_calibration_mode_gate, o_cal_active};
  mdcr_row_t rows [10] = '{
    '{16'h0020, 32'hFFFF_FFFF, 32'h0000_01BF, 18'h3_F900},
    '{16'h0023, 32'hFFFF_FFFE, 32'h0000_0002, 18'h3_FC00},
    '{16'h0023, 32'h0000_0001, 32'h0000_0001, 18'h3_FA00},
    '{16'h0023, 32'h0000_0000, 32'h0000_0000, 18'h3_F900},
    '{16'h0020, 32'h0000_0000, 32'h0000_0000, 18'h0_0100},
    '{16'h0024, 32'hFFFF_FFFF, 32'h0000_0000, 18'h0_0100},
    '{16'h0030, 32'hFFFF_FF7C, 32'h0000_007C, 18'h0_01F8},
    '{16'h0023, 32'h0000_0003, 32'h0000_0003, 18'h0_01F8},
    '{16'h0020, 32'h0000_0115, 32'h0000_0115, 18'h2_59F8},
    '{16'h0020, 32'h0000_00A8, 32'h0000_00A8, 18'h1_A1F8}};
  logic [15:0] adr [3] = '{16'h0020, 16'h0023, 16'h0030};
  // ==========================================
  // clock, design and host
  always #12.5 i_clk_sys = ~i_clk_sys;
  mdcr_regs DUT
  (
    .i_clk_sys, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
    .o_reactive_lpf_bypass, .o_active_lpf_bypass, .o_nominal_voltage_use,
    .o_overcurrent_rms_source, .o_zero_cross_source, .o_chan_b_integrator_on,
    .o_highpass_bypass_all, .o_chan_b_amp_gain, .o_chan_b_gain_factor, .o_voltage_cal_enable,
    .o_chan_b_cal_enable, .o_chan_a_cal_enable, .o_chan_b_cal_power_mode,
    .o_chan_a_cal_power_mode, .o_cal_run, .o_calibration_mode_gate, .o_cal_active
  );
  mdcr_host u_host
  (
    .i_clk_sys, .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata)
  );
  // ==========================================
  // compare, verdict, reset check
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rst_chk;
    logic [31:0] q;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    chk(32'(obs), 32'h0000_0100);
    chk(32'(o_chan_b_amp_gain), 32'h0000_0000);
    for (int k = 0; k < 3; k++)
    begin
      u_host.xfer(1'b0, adr[k], 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
    end
  endtask
  // main sequence: reset, rows, gate, second reset
  initial
  begin
    logic [31:0] q;
    rst_chk();
    for (int k = 0; k < 10; k++)
    begin
      u_host.xfer(1'b1, rows[k].a, rows[k].d, q);
      chk(32'(obs), 32'(rows[k].o));
      u_host.xfer(1'b0, rows[k].a, 32'h0000_0000, q);
      chk(q, rows[k].r);
      if (rows[k].a == 16'h0023)
      begin
        chk(32'(o_chan_b_amp_gain), rows[k].r);
      end
    end
    u_host.xfer(1'b1, 16'h0030, 32'h0000_0003, q);
    chk(32'(obs), 32'h0001_A107);
    u_host.xfer(1'b1, 16'h0020, 32'h0000_0000, q);
    u_host.xfer(1'b0, 16'h0020, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk(32'(obs), 32'h0001_A107);
    u_host.xfer(1'b1, 16'h0023, 32'h0000_0001, q);
    u_host.xfer(1'b0, 16'h0023, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk(32'(o_chan_b_amp_gain), 32'h0000_0003);
    u_host.xfer(1'b0, 16'h0030, 32'h0000_0000, q);
    chk(q, 32'h0000_0003);
    u_host.xfer(1'b1, 16'h0030, 32'h0000_0002, q);
    chk(32'(obs), 32'h0001_A104);
    u_host.xfer(1'b0, 16'h0020, 32'h0000_0000, q);
    chk(q, 32'h0000_00A8);
    rst_chk();
    print_verdict();
  end
  // watchdog against a hang
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule
bind mdcr_regs mdcr_props u_props
(
  .i_clk_sys, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rvalid, .o_reactive_lpf_bypass,
  .o_highpass_bypass_all, .o_chan_b_amp_gain, .o_chan_b_gain_factor, .o_cal_run,
  .o_calibration_mode_gate, .o_cal_active
);
`default_nettype wire
